/* File: hdl/usbd_ctrl.sv */
// USB device control, toggle, suspend/resume and wake logic with AXI4-Lite registers
// Function
// R1: Hardware keeps data toggle per endpoint.
// R2: Receive toggle flips only on accepted good data.
// R3: Transmit toggle flips only on host ACK.
// R4: No toggle handling for isochronous endpoints.
// R5: Endpoints one to three alternate two banks.
// R6: Pull-up connected only while control bit set.
// R7: Endpoint and protocol interrupt vectors provided.
// R8: Endpoint summary shows only pending endpoints.
// R9: Mask bits and global enable gate interrupts.
// R10: Bus idle three milliseconds sets suspend flag.
// R11: Suspend entry switches oscillator off.
// R12: Firmware enters power-down after suspend.
// R13: Resume in suspend wakes chip, sets flag.
// R14: Oscillator not restarted by hardware on resume.
// R15: Wake request drives K only if permitted.
// R16: Wake request sets the wake-sent flag.
// R17: K ends after thirteen milliseconds, clears progress.
// R18: Firmware clears wake request after progress ends.
// R19: Module enable clear resets controller, transceiver off.
// R20: Logic runs only if enabled and ungated.
// R21: Reset falling edge sets unmaskable reset-end flag.
// R22: Start-of-frame PID sets frame flag.
// R23: Resume signalling sets resume flag.
// R24: Detected suspend sets suspend flag.
// R25: Request lines OR masked flags, reset-end unmasked.
`timescale 1ns/1ps
module usbd_ctrl #(
  parameter int unsigned ADDR_W           = 12,
  parameter int unsigned SUSPEND_IDLE_CYC = usbd_pkg::SUSPEND_IDLE_CYC,
  parameter int unsigned WAKE_K_CYC       = usbd_pkg::WAKE_K_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  input  wire usbd_pkg::usbd_sie_ev_s sie_ev,
  input  wire logic [7:0]            ep_iso,
  input  wire logic [7:0]            ep_can_accept,
  input  wire logic [7:0]            ep_event_src,
  input  wire logic                  usb_power_gate,
  input  wire logic                  global_irq_enable,
  output logic [7:0]                 rx_accept,
  output logic [7:0]                 rx_data1_exp,
  output logic [7:0]                 tx_data1,
  output logic [7:0]                 rx_bank,
  output logic [7:0]                 tx_bank,
  output logic                       pullup_connect,
  output logic                       xcvr_enable,
  output logic                       usb_run,
  output logic                       osc_stop,
  output logic                       chip_wake,
  output logic                       drive_k,
  output logic                       irq_endpoint,
  output logic                       irq_protocol
);
  initial begin
    if (ADDR_W < 10) $error("usbd_ctrl: ADDR_W must be at least 10");
    if (SUSPEND_IDLE_CYC < 2 || WAKE_K_CYC < 2) $error("usbd_ctrl: counts too small");
  end

  typedef struct packed {
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [7:0]        ctrl;
    logic [7:0]        flags;
    logic [7:0]        mask;
    logic [7:0]        ep_mask;
    logic              permit;
    logic              rip;
    logic              osc_off;
    logic              suspended;
    logic              drive_k;
    logic              wake;
    logic              rst_prev;
    logic              wreq_prev;
  } usbd_st_s;

  usbd_st_s st_r;
  usbd_st_s st_nxt;

  logic       run_ok;
  logic       enabled;
  logic       idle_done;
  logic       wake_done;
  logic       wr_fire;
  logic [7:0] rx_good;
  logic [7:0] tx_good;
  logic [7:0] rx_tog;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction : hit

  assign enabled = st_r.ctrl[usbd_pkg::CTRL_ENABLE];
  assign run_ok  = enabled && !usb_power_gate; // R20
  assign wr_fire = st_r.aw_have && st_r.w_have && !st_r.bvalid;

  ////////////////////////////////////////////////////////////////////////////////
  // Endpoint sequence bits

  for (genvar e = 0; e < 8; e++) begin : g_ep
    logic rx_sel;
    logic tx_sel;
    assign rx_sel = sie_ev.rx_done && sie_ev.rx_ep == 3'(e);
    assign tx_sel = sie_ev.tx_ack && sie_ev.tx_ep == 3'(e);
    // Accepted only if space, good CRC and, unless isochronous, the expected PID
    assign rx_good[e] = rx_sel && sie_ev.rx_crc_ok && ep_can_accept[e]
                        && (ep_iso[e] || sie_ev.rx_data1 == rx_tog[e]); // R2 R4
    assign tx_good[e] = tx_sel; // R3
    usbd_ep_seq #(
      .DOUBLE_BANK (usbd_pkg::DOUBLE_BANK_EPS[e])
    ) u_seq (
      .clock   (clock),
      .rst     (rst),
      .clear   (!enabled),
      .run     (run_ok),
      .iso     (ep_iso[e]),
      .rx_ok   (rx_good[e]),
      .tx_ok   (tx_good[e]),
      .rx_tog  (rx_tog[e]),
      .tx_tog  (tx_data1[e]),
      .rx_bank (rx_bank[e]),
      .tx_bank (tx_bank[e])
    ); // R1 R5
  end

  assign rx_accept    = run_ok ? rx_good : 8'h00;
  assign rx_data1_exp = rx_tog;

  ////////////////////////////////////////////////////////////////////////////////
  // Timers

  usbd_timer #(
    .COUNT (SUSPEND_IDLE_CYC)
  ) u_idle (
    .clock (clock),
    .rst   (rst),
    .clear (sie_ev.activity || !enabled || st_r.suspended),
    .step  (run_ok),
    .done  (idle_done)
  ); // R10

  usbd_timer #(
    .COUNT (WAKE_K_CYC)
  ) u_wake (
    .clock (clock),
    .rst   (rst),
    .clear (!st_r.drive_k || !enabled),
    .step  (run_ok),
    .done  (wake_done)
  ); // R17

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [ADDR_W-1:0] a;
    logic [7:0]        d;
    logic              mapped;
    a      = st_r.aw_addr;
    d      = st_r.w_data;
    mapped = 1'b0;
    st_nxt = st_r;
    st_nxt.wake = 1'b0;

    // Write address and data may arrive in either order
    if (s_axi_awvalid && !st_r.aw_have) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_have) begin
      st_nxt.w_have  = 1'b1;
      st_nxt.w_data  = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;

    if (wr_fire) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      mapped = hit(a, usbd_pkg::IDX_CTRL) || hit(a, usbd_pkg::IDX_FLAGS)
               || hit(a, usbd_pkg::IDX_MASK) || hit(a, usbd_pkg::IDX_EPSUM)
               || hit(a, usbd_pkg::IDX_EPMASK) || hit(a, usbd_pkg::IDX_GSTAT);
      st_nxt.bresp = mapped ? usbd_pkg::RESP_OKAY : usbd_pkg::RESP_SLVERR;
      if (st_r.w_lane0) begin
        if (hit(a, usbd_pkg::IDX_CTRL)) st_nxt.ctrl = d & usbd_pkg::CTRL_WMASK; // R6 R19
        // Flags take the written value: zero clears, one sets
        if (hit(a, usbd_pkg::IDX_FLAGS)) st_nxt.flags = d & usbd_pkg::FLAGS_WMASK;
        if (hit(a, usbd_pkg::IDX_MASK)) st_nxt.mask = d & usbd_pkg::MASK_WMASK; // R9
        if (hit(a, usbd_pkg::IDX_EPMASK)) st_nxt.ep_mask = d; // R9
        if (hit(a, usbd_pkg::IDX_GSTAT)) begin
          st_nxt.permit = d[usbd_pkg::GS_PERMIT];
          // Only firmware restarts the oscillator
          if (!d[usbd_pkg::GS_OSC_OFF]) st_nxt.osc_off = 1'b0; // R14
        end
      end
    end

    // Hardware events come last so that a set beats a clear
    if (!enabled) begin
      st_nxt.suspended = 1'b0; // R19
      st_nxt.drive_k   = 1'b0;
      st_nxt.rip       = 1'b0;
      st_nxt.rst_prev  = 1'b0;
      st_nxt.wreq_prev = 1'b0;
    end else if (run_ok) begin
      st_nxt.rst_prev  = sie_ev.bus_reset;
      st_nxt.wreq_prev = st_r.ctrl[usbd_pkg::CTRL_WAKE_REQ];
      if (st_r.rst_prev && !sie_ev.bus_reset) begin
        st_nxt.flags[usbd_pkg::FLG_RESET_END] = 1'b1; // R21
      end
      if (sie_ev.sof) st_nxt.flags[usbd_pkg::FLG_FRAME] = 1'b1; // R22
      if (sie_ev.activity) st_nxt.suspended = 1'b0;
      if (idle_done) begin
        st_nxt.flags[usbd_pkg::FLG_SUSPEND] = 1'b1; // R10 R24
        st_nxt.suspended = 1'b1;
        st_nxt.osc_off   = 1'b1; // R11
      end
      if (sie_ev.resume_k) begin
        st_nxt.flags[usbd_pkg::FLG_RESUME] = 1'b1; // R23
        if (st_r.suspended) begin
          st_nxt.wake      = 1'b1; // R13
          st_nxt.suspended = 1'b0;
        end
      end
      if (st_r.ctrl[usbd_pkg::CTRL_WAKE_REQ] && !st_r.wreq_prev) begin
        st_nxt.flags[usbd_pkg::FLG_WAKE_SENT] = 1'b1; // R16
        if (st_r.permit && !st_r.rip) begin
          st_nxt.drive_k = 1'b1; // R15
          st_nxt.rip     = 1'b1;
        end
      end
      if (wake_done) begin
        st_nxt.drive_k = 1'b0; // R17
        st_nxt.rip     = 1'b0;
      end
    end

    // Read channel; one read outstanding at a time
    if (st_r.rvalid && s_axi_rready) st_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = usbd_pkg::RESP_OKAY;
      st_nxt.rdata  = 8'h00;
      if (hit(s_axi_araddr, usbd_pkg::IDX_CTRL)) st_nxt.rdata = st_r.ctrl;
      else if (hit(s_axi_araddr, usbd_pkg::IDX_FLAGS)) st_nxt.rdata = st_r.flags;
      else if (hit(s_axi_araddr, usbd_pkg::IDX_MASK)) st_nxt.rdata = st_r.mask;
      else if (hit(s_axi_araddr, usbd_pkg::IDX_EPSUM)) st_nxt.rdata = ep_event_src; // R8
      else if (hit(s_axi_araddr, usbd_pkg::IDX_EPMASK)) st_nxt.rdata = st_r.ep_mask;
      else if (hit(s_axi_araddr, usbd_pkg::IDX_GSTAT)) begin
        st_nxt.rdata = {4'h0, st_r.suspended, st_r.osc_off, st_r.rip, st_r.permit};
      end else st_nxt.rresp = usbd_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r         <= '0;
      st_r.ctrl    <= usbd_pkg::CTRL_RST;
      st_r.flags   <= usbd_pkg::FLAGS_RST;
      st_r.mask    <= usbd_pkg::MASK_RST;
      st_r.ep_mask <= usbd_pkg::EPMASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready  = !st_r.aw_have;
  assign s_axi_wready   = !st_r.w_have;
  assign s_axi_bvalid   = st_r.bvalid;
  assign s_axi_bresp    = st_r.bresp;
  assign s_axi_arready  = !st_r.rvalid;
  assign s_axi_rvalid   = st_r.rvalid;
  assign s_axi_rdata    = {24'h000000, st_r.rdata};
  assign s_axi_rresp    = st_r.rresp;
  assign pullup_connect = st_r.ctrl[usbd_pkg::CTRL_PULLUP]; // R6
  assign xcvr_enable    = enabled; // R19
  assign usb_run        = run_ok; // R20
  assign osc_stop       = st_r.osc_off;
  assign chip_wake      = st_r.wake;
  assign drive_k        = st_r.drive_k;
  // These lines feed the vectors at EP_VECTOR_ADDR and PROTO_VECTOR_ADDR
  assign irq_endpoint = global_irq_enable && |(ep_event_src & st_r.ep_mask); // R7 R8 R9 R25
  assign irq_protocol = global_irq_enable
                        && (st_r.flags[usbd_pkg::FLG_RESET_END]
                            || |(st_r.flags[3:0] & st_r.mask[3:0])); // R7 R9 R21 R25

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_PULLUP_CAUSE: assert property ( // R6
    $rose(pullup_connect) |-> $past(wr_fire && hit(st_r.aw_addr, usbd_pkg::IDX_CTRL)))
    else $error("pull-up connected without a control write");
  AST_RX_TOG_CAUSE: assert property ( // R2
    $changed(rx_tog) |-> $past(rx_good != 8'h00 && run_ok) || $past(!enabled))
    else $error("receive toggle moved without accepted data");
  AST_TX_TOG_CAUSE: assert property ( // R3
    $changed(tx_data1) |-> $past(tx_good != 8'h00 && run_ok) || $past(!enabled))
    else $error("transmit toggle moved without ACK");
  AST_ISO_HOLD: assert property ( // R4
    (run_ok && (rx_good & ep_iso) == rx_good && (tx_good & ep_iso) == tx_good)
    |=> $stable(rx_tog) && $stable(tx_data1))
    else $error("isochronous traffic moved a toggle");
  AST_GIE_GATE: assert property ( // R9
    !global_irq_enable |-> !irq_endpoint && !irq_protocol)
    else $error("interrupt raised with global enable off");
  AST_SUSPEND_SET: assert property ( // R10
    idle_done |=> st_r.flags[usbd_pkg::FLG_SUSPEND] && osc_stop && st_r.suspended)
    else $error("idle bus did not enter suspend");
  AST_RESUME_WAKE: assert property ( // R13
    (run_ok && st_r.suspended && sie_ev.resume_k)
    |=> chip_wake && st_r.flags[usbd_pkg::FLG_RESUME] ##1 !chip_wake)
    else $error("resume in suspend did not wake once");
  AST_WAKE_START: assert property ( // R15
    $rose(drive_k) |-> $past(st_r.permit) && st_r.flags[usbd_pkg::FLG_WAKE_SENT])
    else $error("K driven without permission");
  AST_WAKE_END: assert property ( // R17
    $fell(st_r.rip) && $past(enabled) |-> $past(wake_done) && !drive_k)
    else $error("wake ended before its time");
  AST_RESET_END: assert property ( // R21
    (run_ok && st_r.rst_prev && !sie_ev.bus_reset)
    |=> st_r.flags[usbd_pkg::FLG_RESET_END] && (irq_protocol == global_irq_enable))
    else $error("reset end not flagged unmasked");
  AST_FRAME_SET: assert property ( // R22
    (run_ok && sie_ev.sof) |=> st_r.flags[usbd_pkg::FLG_FRAME])
    else $error("frame start not flagged");

  COV_SUSPEND: cover property (idle_done ##[1:100] chip_wake);
  COV_WAKE:    cover property ($rose(drive_k) ##[1:1000] $fell(st_r.rip));
  COV_RESET:   cover property ($fell(sie_ev.bus_reset) ##1 irq_protocol);
endmodule : usbd_ctrl

/* File: hdl/usbd_pkg.sv */
// Shared constants and types of the USB device control and event block
package usbd_pkg;
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned CLK_PER_MS       = CLK_HZ / 1000;
  localparam int unsigned SUSPEND_IDLE_MS  = 3;
  localparam int unsigned WAKE_K_MS        = 13;
  localparam int unsigned SUSPEND_IDLE_CYC = SUSPEND_IDLE_MS * CLK_PER_MS;
  localparam int unsigned WAKE_K_CYC       = WAKE_K_MS * CLK_PER_MS;
  localparam int unsigned NUM_EP           = 8;
  localparam int unsigned EP_BANK_BYTES    = 64;
  localparam logic [7:0]  DOUBLE_BANK_EPS  = 8'h0e;
  localparam logic [15:0] EP_VECTOR_ADDR   = 16'h003e;
  localparam logic [15:0] PROTO_VECTOR_ADDR = 16'h0040;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL   = 8'he0;
  localparam logic [7:0] IDX_FLAGS  = 8'he1;
  localparam logic [7:0] IDX_MASK   = 8'he2;
  localparam logic [7:0] IDX_EPSUM  = 8'he3;
  localparam logic [7:0] IDX_EPMASK = 8'he4;
  localparam logic [7:0] IDX_GSTAT  = 8'he5;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h02;
  localparam logic [7:0] EPMASK_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'ha2;
  localparam logic [7:0] FLAGS_WMASK = 8'h1f;
  localparam logic [7:0] MASK_WMASK = 8'h0f;
  localparam int unsigned CTRL_WAKE_REQ = 7;
  localparam int unsigned CTRL_PULLUP   = 5;
  localparam int unsigned CTRL_ENABLE   = 1;
  localparam int unsigned FLG_RESET_END = 4;
  localparam int unsigned FLG_FRAME     = 3;
  localparam int unsigned FLG_WAKE_SENT = 2;
  localparam int unsigned FLG_RESUME    = 1;
  localparam int unsigned FLG_SUSPEND   = 0;
  localparam int unsigned GS_PERMIT     = 0;
  localparam int unsigned GS_RIP        = 1;
  localparam int unsigned GS_OSC_OFF    = 2;
  localparam int unsigned GS_SUSPENDED  = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Events reported by the serial engine, all on this clock
  typedef struct packed {
    logic       rx_done;
    logic [2:0] rx_ep;
    logic       rx_data1;
    logic       rx_crc_ok;
    logic       tx_ack;
    logic [2:0] tx_ep;
    logic       sof;
    logic       resume_k;
    logic       bus_reset;
    logic       activity;
  } usbd_sie_ev_s;
endpackage : usbd_pkg

/* File: hdl/usbd_timer.sv */
// Saturating cycle timer that pulses once when its count is reached
`timescale 1ns/1ps
module usbd_timer #(
  parameter int unsigned COUNT = 16
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic step,
  output logic      done
);
  localparam int unsigned W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);
  localparam logic [W-1:0] FULL = W'(COUNT);

  initial begin
    if (COUNT < 1) $error("usbd_timer: COUNT must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } usbd_tmr_s;

  usbd_tmr_s st_r;
  usbd_tmr_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    done   = step && !clear && (st_r.cnt == LAST);
    if (clear) begin
      st_nxt.cnt = '0;
    end else if (step && st_r.cnt != FULL) begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end
endmodule : usbd_timer

/* File: hdl/usbd_ep_seq.sv */
// Per-endpoint data toggle and bank pointers
`timescale 1ns/1ps
module usbd_ep_seq #(
  parameter bit DOUBLE_BANK = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic run,
  input  wire logic iso,
  input  wire logic rx_ok,
  input  wire logic tx_ok,
  output logic      rx_tog,
  output logic      tx_tog,
  output logic      rx_bank,
  output logic      tx_bank
);
  typedef struct packed {
    logic rx_tog;
    logic tx_tog;
    logic rx_bank;
    logic tx_bank;
  } usbd_seq_s;

  usbd_seq_s st_r;
  usbd_seq_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt = '0;
    end else if (run) begin
      // Isochronous traffic never advances the data toggles
      if (rx_ok && !iso) st_nxt.rx_tog = !st_r.rx_tog; // R2 R4
      if (tx_ok && !iso) st_nxt.tx_tog = !st_r.tx_tog; // R3 R4
      // Banks alternate on every completed packet, iso included
      if (DOUBLE_BANK && rx_ok) st_nxt.rx_bank = !st_r.rx_bank; // R5
      if (DOUBLE_BANK && tx_ok) st_nxt.tx_bank = !st_r.tx_bank; // R5
    end
  end

  always_ff @(posedge clock) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign rx_tog  = st_r.rx_tog;
  assign tx_tog  = st_r.tx_tog;
  assign rx_bank = st_r.rx_bank;
  assign tx_bank = st_r.tx_bank;
endmodule : usbd_ep_seq

/* File: tb/usbd_host_model.sv */
// Behavioural full-speed host: issues bus events toward the device
`timescale 1ns/1ps
module usbd_host_model (
  input  wire logic              clock,
  output usbd_pkg::usbd_sie_ev_s sie_ev
);
  initial sie_ev = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Kind: 0 data out, 1 ack of data in, 2 frame start, 3 resume K, 4 bus reset
  task automatic send(input int kind, input logic [2:0] ep, input logic d1, input logic ok);
    usbd_pkg::usbd_sie_ev_s e;
    e = '{rx_done: kind == 0, rx_ep: ep, rx_data1: d1, rx_crc_ok: ok, tx_ack: kind == 1,
          tx_ep: ep, sof: kind == 2, resume_k: kind == 3, bus_reset: kind == 4,
          activity: kind != 3};
    sie_ev <= e;
    repeat (kind == 4 ? 3 : 1) @(posedge clock);
    // Released payload shows the inverse so a stale value never passes; strobes drop
    e = '{rx_ep: ~ep, tx_ep: ~ep, rx_data1: ~d1, rx_crc_ok: ~ok, default: '0};
    sie_ev <= e;
    @(posedge clock);
  endtask : send
endmodule : usbd_host_model

/* File: tb/usbd_ctrl_tb.sv */
// Self-checking bench for the USB device control and event block
`timescale 1ns/1ps
module usbd_ctrl_tb;
  localparam int SI = 20;
  localparam int WK = 30;
  logic clock = 1'b0, rst = 1'b1, usb_power_gate = 1'b0, global_irq_enable = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] ep_iso = 8'h80, ep_can_accept = 8'hff, ep_event_src = 8'h00;
  logic [7:0] rx_accept, rx_data1_exp, tx_data1, rx_bank, tx_bank;
  logic pullup_connect, xcvr_enable, usb_run, osc_stop, chip_wake, drive_k;
  logic irq_endpoint, irq_protocol, d1;
  logic [7:0] er = '0, et = '0, rb = '0, tbk = '0, can;
  logic [31:0] r;
  logic [2:0] ep;
  usbd_pkg::usbd_sie_ev_s sie_ev;
  int seed = 32'hc5ff, err_count = 0, num_checks = 0, wakes = 0, kcyc = 0, acc = 0, xacc = 0;

  usbd_ctrl #(.SUSPEND_IDLE_CYC(SI), .WAKE_K_CYC(WK)) usbd_ctrl_i (.clock, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sie_ev, .ep_iso,
    .ep_can_accept, .ep_event_src, .usb_power_gate, .global_irq_enable, .rx_accept,
    .rx_data1_exp, .tx_data1, .rx_bank, .tx_bank, .pullup_connect, .xcvr_enable, .usb_run,
    .osc_stop, .chip_wake, .drive_k, .irq_endpoint, .irq_protocol);
  usbd_host_model usbd_host_model_i (.clock, .sie_ev);

  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (chip_wake) wakes <= wakes + 1;
    if (drive_k) kcyc <= kcyc + 1;
    acc <= acc + $countones(rx_accept);
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba
  // Receive toggle flips only for accepted, clean, in-sequence, non-isochronous data
  function automatic logic rx_ok(input logic iso, ok, pid, ex, room);
    return !iso && ok && (pid == ex) && room;
  endfunction : rx_ok
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic a, w, b;
    logic [1:0] rs;
    s_axi_awaddr <= ba(i);
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clock);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      rs = s_axi_bresp;
      @(posedge clock);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    chk("bresp", rs, usbd_pkg::RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] m, input logic [7:0] x,
                    input logic [1:0] xr);
    logic a, v;
    logic [31:0] d;
    logic [1:0] rs;
    s_axi_araddr <= ba(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge clock);
      a = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
      if (a) s_axi_arvalid <= 1'b0;
    end
    chk("rdata", d & {24'hffffff, m}, {24'h0, x});
    chk("rresp", rs, xr);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("pullup", pullup_connect, 0);
    rd(usbd_pkg::IDX_CTRL, 8'hff, usbd_pkg::CTRL_RST, usbd_pkg::RESP_OKAY);
    rd(usbd_pkg::IDX_FLAGS, 8'hff, usbd_pkg::FLAGS_RST, usbd_pkg::RESP_OKAY);
    rd(usbd_pkg::IDX_MASK, 8'hff, usbd_pkg::MASK_RST, usbd_pkg::RESP_OKAY);
    rd(8'he8, 8'hff, 8'h00, usbd_pkg::RESP_SLVERR);
    wr(usbd_pkg::IDX_CTRL, 8'h7f);
    @(posedge clock);
    rd(usbd_pkg::IDX_CTRL, 8'hff, 8'h22, usbd_pkg::RESP_OKAY);
    chk("attach", {pullup_connect, xcvr_enable, usb_run}, 3'b111);
    r = $random(seed);
    ep_event_src <= r[7:0];
    global_irq_enable <= 1'b1;
    wr(usbd_pkg::IDX_EPMASK, r[15:8]);
    wr(usbd_pkg::IDX_EPSUM, ~r[7:0]);
    rd(usbd_pkg::IDX_EPSUM, 8'hff, r[7:0], usbd_pkg::RESP_OKAY);
    chk("ep irq", irq_endpoint, |(r[7:0] & r[15:8]));
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      ep = r[2:0];
      d1 = er[ep] ^ (r[3] & r[4]);
      can = r[15:8] | r[23:16];
      ep_can_accept <= can;
      usbd_host_model_i.send(int'(r[5]), ep, d1, r[6] | r[7]);
      xacc += !r[5] && (r[6] | r[7]) && can[ep] && (ep_iso[ep] || d1 == er[ep]);
      if (!r[5] && rx_ok(ep_iso[ep], r[6] | r[7], d1, er[ep], can[ep])) begin
        er[ep] = ~er[ep];
        rb[ep] = rb[ep] ^ usbd_pkg::DOUBLE_BANK_EPS[ep];
      end
      if (r[5] && !ep_iso[ep]) begin
        et[ep] = ~et[ep];
        tbk[ep] = tbk[ep] ^ usbd_pkg::DOUBLE_BANK_EPS[ep];
      end
      chk("rx toggle", rx_data1_exp, er);
      chk("tx toggle", tx_data1, et);
      chk("banks", {rx_bank, tx_bank}, {rb, tbk});
    end
    chk("accepts", acc, xacc);
    wr(usbd_pkg::IDX_FLAGS, 8'h00);
    repeat (SI + 4) @(posedge clock);
    rd(usbd_pkg::IDX_FLAGS, 8'hff, 8'h01, usbd_pkg::RESP_OKAY);
    rd(usbd_pkg::IDX_GSTAT, 8'h0c, 8'h0c, usbd_pkg::RESP_OKAY);
    usbd_host_model_i.send(3, 3'h0, 1'b0, 1'b0);
    chk("osc stays off", osc_stop, 1);
    rd(usbd_pkg::IDX_FLAGS, 8'hff, 8'h03, usbd_pkg::RESP_OKAY);
    chk("wake pulses", wakes, 1);
    chk("irq resume", irq_protocol, 1);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clock);
    chk("irq gated", {irq_protocol, irq_endpoint}, 2'b00);
    global_irq_enable <= 1'b1;
    wr(usbd_pkg::IDX_GSTAT, 8'h00);
    wr(usbd_pkg::IDX_FLAGS, 8'h00);
    usbd_host_model_i.send(2, 3'h0, 1'b0, 1'b1);
    usbd_host_model_i.send(4, 3'h0, 1'b0, 1'b1);
    rd(usbd_pkg::IDX_FLAGS, 8'hff, 8'h18, usbd_pkg::RESP_OKAY);
    wr(usbd_pkg::IDX_MASK, 8'h00);
    chk("reset end unmasked", irq_protocol, 1);
    wr(usbd_pkg::IDX_FLAGS, 8'h08);
    chk("frame masked", irq_protocol, 0);
    wr(usbd_pkg::IDX_MASK, 8'h08);
    chk("frame unmasked", irq_protocol, 1);
    wr(usbd_pkg::IDX_GSTAT, 8'h01);
    wr(usbd_pkg::IDX_CTRL, 8'ha2);
    repeat (3) @(posedge clock);
    chk("k on", drive_k, 1);
    // Frame starts keep the bus busy so suspend stays out of the picture
    repeat (6) begin
      usbd_host_model_i.send(2, 3'h0, 1'b0, 1'b1);
      repeat (5) @(posedge clock);
    end
    chk("k length", kcyc >= WK - 1 && kcyc <= WK + 1, 1);
    rd(usbd_pkg::IDX_GSTAT, 8'h02, 8'h00, usbd_pkg::RESP_OKAY);
    rd(usbd_pkg::IDX_FLAGS, 8'h04, 8'h04, usbd_pkg::RESP_OKAY);
    wr(usbd_pkg::IDX_CTRL, 8'h22);
    wr(usbd_pkg::IDX_FLAGS, 8'h00);
    wr(usbd_pkg::IDX_GSTAT, 8'h00);
    wr(usbd_pkg::IDX_CTRL, 8'ha2);
    repeat (3) @(posedge clock);
    chk("k needs permit", drive_k, 0);
    rd(usbd_pkg::IDX_FLAGS, 8'h04, 8'h04, usbd_pkg::RESP_OKAY);
    wr(usbd_pkg::IDX_CTRL, 8'h22);
    wr(usbd_pkg::IDX_FLAGS, 8'h00);
    usb_power_gate <= 1'b1;
    usbd_host_model_i.send(2, 3'h0, 1'b0, 1'b1);
    chk("gated run", usb_run, 0);
    rd(usbd_pkg::IDX_FLAGS, 8'h08, 8'h00, usbd_pkg::RESP_OKAY);
    usb_power_gate <= 1'b0;
    wr(usbd_pkg::IDX_CTRL, 8'h00);
    @(posedge clock);
    chk("disabled", {pullup_connect, xcvr_enable, usb_run}, 3'b000);
    chk("toggles cleared", {rx_data1_exp, tx_data1}, 16'h0000);
    complete_run();
  end
endmodule : usbd_ctrl_tb
